// [lfp_pkg.sv]
// Constants, codes and state types for the loop frame protocol station.
// Assumes a single 100 MHz clock and a loop bit clock far slower than it.
package lfp_pkg;

  localparam int unsigned lfp_word_bits = 9;
  localparam logic [3:0] lfp_last_bit = 4'h8;
  localparam logic [2:0] lfp_last_byte = 3'h4;
  localparam logic [2:0] lfp_byte_addr = 3'h1;
  localparam logic [2:0] lfp_byte_dev = 3'h2;
  localparam logic [2:0] lfp_byte_ctl = 3'h3;
  localparam logic [2:0] lfp_byte_data = 3'h4;

  // Frame field codes.
  localparam logic [7:0] lfp_code_start = 8'h39;
  localparam logic [7:0] lfp_code_sync = 8'h47;
  localparam logic [7:0] lfp_code_any = 8'h11;
  localparam logic [7:0] lfp_code_all = 8'h09;
  localparam logic [7:0] lfp_code_diag_dev = 8'h00;

  // Commands from the loop adapter.
  localparam logic [7:0] lfp_cmd_read = 8'h06;
  localparam logic [7:0] lfp_cmd_read_null = 8'h02;
  localparam logic [7:0] lfp_cmd_read_data = 8'h0a;
  localparam logic [7:0] lfp_cmd_read_end = 8'h0e;
  localparam logic [7:0] lfp_cmd_diag_begin = 8'h08;
  localparam logic [7:0] lfp_cmd_diag_end = 8'h0c;

  // Responses from this station.
  localparam logic [7:0] lfp_rsp_read_req = 8'h12;
  localparam logic [7:0] lfp_rsp_read_ack = 8'h46;
  localparam logic [7:0] lfp_rsp_data_req = 8'h62;
  localparam logic [7:0] lfp_rsp_data_ack = 8'h6a;
  localparam logic [7:0] lfp_rsp_end_req = 8'h72;
  localparam logic [7:0] lfp_rsp_end_ack = 8'h3e;
  localparam logic [7:0] lfp_rsp_null_ack = 8'h42;
  localparam logic [7:0] lfp_rsp_diag_begin = 8'h68;
  localparam logic [7:0] lfp_rsp_diag_end = 8'h4c;

  // Field positions.
  localparam int unsigned lfp_addr_top = 7;
  localparam int unsigned lfp_rsp_hi = 7;
  localparam int unsigned lfp_rsp_lo = 4;
  localparam int unsigned lfp_op_hi = 1;
  localparam logic [1:0] lfp_op_diag = 2'b00;

  // Software register map, word addresses on the command port.
  localparam int unsigned lfp_reg_aw = 4;
  localparam int unsigned lfp_reg_dw = 16;
  localparam logic [3:0] lfp_reg_ctrl = 4'h0;
  localparam logic [3:0] lfp_reg_addr = 4'h1;
  localparam logic [3:0] lfp_reg_txdata = 4'h2;
  localparam logic [3:0] lfp_reg_end = 4'h3;
  localparam logic [3:0] lfp_reg_req = 4'h4;
  localparam logic [3:0] lfp_reg_status = 4'h5;
  localparam int unsigned lfp_ctrl_enable = 0;
  localparam int unsigned lfp_status_perr = 0;
  localparam logic [7:0] lfp_own_reset = 8'h80;
  localparam logic [7:0] lfp_dev_reset = 8'h40;

  typedef enum logic [1:0] {
    lfp_hunt = 2'b00,
    lfp_between = 2'b01,
    lfp_inframe = 2'b10
  } lfp_align_type;

  typedef enum logic [1:0] {
    lfp_idle = 2'b00,
    lfp_claimed = 2'b01,
    lfp_datamode = 2'b10
  } lfp_op_type;

endpackage

// [lfp_station.sv]
// Remote terminal station on the serial transmission loop.
// Assumes the loop bit clock and data arrive as plain pins, far slower than clk.
// What this block does
// - Frame is start, station, device, control, data.
// - Start even parity; all other bytes odd.
// - Start 39 and sync 47 give byte alignment.
// - Frame ends after five bytes counted.
// - Discrete station addresses lie in 80 to FF.
// - Addressed or captured frame gets our address rewritten.
// - Claim open frame 11 by writing own address.
// - Broadcast 09 address is never altered; only diagnostic commands execute.
// - Device byte: two adapter bits, six device bits.
// - Diagnostic commands run whatever the device byte.
// - Control: low nibble command, high nibble response.
// - Response: restore ack, data mode, two stage bits.
// - Data-mode flag set in data mode and diagnostics.
// - Commands have zero response nibble; responses not.
// - Station answers every command valid for it, except broadcast diagnostics, which run unanswered.
// - Data passes untouched unless we fill it; end status zero or 80, but any byte software writes is sent.
// - Each read byte is sent twice in two frames.
// - Read data 0A answered 6A with same byte.
// - Check sync each byte between frames; else hunt every bit.
// - Read replies use codes 12, 46 and 62.
`timescale 1ns/1ns
module lfp_station
  import lfp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic loop_clk_in,
  input wire logic loop_data_in,
  output logic loop_clk_out,
  output logic loop_data_out,
  input wire logic [lfp_pkg::lfp_reg_aw-1:0] reg_addr,
  input wire logic [lfp_pkg::lfp_reg_dw-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lfp_pkg::lfp_reg_dw-1:0] reg_rdata
);
  import lfp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [2:0] data_sync;
    logic clk_lvl;
    logic data_lvl;
    lfp_align_type align;
    logic [3:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [8:0] shift;
    logic [8:0] delay;
    logic out_bit;
    logic out_clk;
    logic fr_own;
    logic fr_cap;
    logic fr_bcast;
    logic fr_cmd;
    logic [1:0] fr_data_sel;
    lfp_op_type op;
    logic enable;
    logic [7:0] own_addr;
    logic [7:0] dev_addr;
    logic svc_req;
    logic [7:0] tx_byte;
    logic tx_avail;
    logic end_req;
    logic [7:0] end_status;
    logic [7:0] guidance;
    logic perr;
    logic diag;
    logic [lfp_reg_dw-1:0] rdata;
  } lfp_state_type;

  localparam logic [1:0] sel_keep = 2'b00;
  localparam logic [1:0] sel_tx = 2'b01;
  localparam logic [1:0] sel_end = 2'b10;
  localparam logic [1:0] sel_guide = 2'b11;

  localparam lfp_state_type lfp_reset = '{
    clk_sync: 3'h0, data_sync: 3'h0, clk_lvl: 1'b0, data_lvl: 1'b0,
    align: lfp_hunt, bit_cnt: 4'h0, byte_cnt: 3'h0, shift: 9'h000,
    delay: 9'h000, out_bit: 1'b0, out_clk: 1'b0, fr_own: 1'b0, fr_cap: 1'b0,
    fr_bcast: 1'b0, fr_cmd: 1'b0, fr_data_sel: 2'b00, op: lfp_idle,
    enable: 1'b0, own_addr: lfp_own_reset, dev_addr: lfp_dev_reset,
    svc_req: 1'b0, tx_byte: 8'h00, tx_avail: 1'b0, end_req: 1'b0,
    end_status: 8'h00, guidance: 8'h00, perr: 1'b0, diag: 1'b0,
    rdata: 16'h0000
  };

  lfp_state_type r;
  lfp_state_type next_r;

  // Appends the odd parity bit to a byte.
  function automatic logic [8:0] odd_word(input logic [7:0] b);
    return {b, ~^b};
  endfunction

  // Appends the even parity bit to a byte.
  function automatic logic [8:0] even_word(input logic [7:0] b);
    return {b, ^b};
  endfunction

  // True when a whole nine-bit word is the sync code with odd parity.
  function automatic logic is_sync(input logic [8:0] w);
    return w == odd_word(lfp_code_sync);
  endfunction

  // True when a whole nine-bit word is the start code with even parity.
  function automatic logic is_start(input logic [8:0] w);
    return w == even_word(lfp_code_start);
  endfunction

  // True on the bit event that completes a nine-bit word.
  function automatic logic byte_done(input logic [3:0] n);
    return n == lfp_last_bit;
  endfunction

  // True when a received word holds odd parity.
  function automatic logic odd_ok(input logic [8:0] w);
    return ^w;
  endfunction

  // A control byte is a command only while its response nibble is zero.
  function automatic logic is_cmd(input logic [7:0] b);
    return b[lfp_rsp_hi:lfp_rsp_lo] == 4'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic bit_evt;
  logic [8:0] word;
  logic [7:0] wbyte;
  logic [8:0] mod_word;
  logic [7:0] cmd;
  logic diag_cmd;
  logic perr_set;

  always_comb begin
    next_r = r;
    bit_evt = 1'b0;
    word = 9'h000;
    wbyte = 8'h00;
    mod_word = 9'h000;
    cmd = 8'h00;
    diag_cmd = 1'b0;
    perr_set = 1'b0;

    // Pin inputs: the first stage feeds only the second. A level counts once stages two and
    // three agree, so a metastable first stage or a one-cycle glitch never makes a bit event.
    next_r.clk_sync = {r.clk_sync[1:0], loop_clk_in};
    next_r.data_sync = {r.data_sync[1:0], loop_data_in};
    if (r.clk_sync[1] == r.clk_sync[2]) begin
      next_r.clk_lvl = r.clk_sync[2];
    end
    if (r.data_sync[1] == r.data_sync[2]) begin
      next_r.data_lvl = r.data_sync[2];
    end
    next_r.out_clk = r.clk_lvl;

    // A bit is taken on the rising edge of the filtered loop clock.
    bit_evt = next_r.clk_lvl && !r.clk_lvl;
    if (bit_evt) begin
      word = {r.shift[7:0], next_r.data_lvl};
      wbyte = word[8:1];
      next_r.shift = word;
      next_r.out_bit = r.delay[8];
      // The outgoing word shifts on its own: a rewritten byte must leave whole, not be
      // overwritten by the raw bits that the receive shifter still holds.
      next_r.delay = {r.delay[7:0], next_r.data_lvl};
      next_r.bit_cnt = byte_done(r.bit_cnt) ? 4'h0 : r.bit_cnt + 4'h1;

      unique case (r.align)
        lfp_hunt: begin
          // Sliding search for sync at every bit position.
          if (is_sync(word)) begin
            next_r.align = lfp_between;
            next_r.bit_cnt = 4'h0;
          end
        end
        lfp_between: begin
          if (byte_done(r.bit_cnt)) begin
            if (is_sync(word)) begin
              next_r.align = lfp_between;
            end else if (is_start(word)) begin
              next_r.align = lfp_inframe;
              next_r.byte_cnt = lfp_byte_addr;
              next_r.fr_own = 1'b0;
              next_r.fr_cap = 1'b0;
              next_r.fr_bcast = 1'b0;
              next_r.fr_cmd = 1'b0;
              next_r.fr_data_sel = sel_keep;
            end else begin
              // A false sync caught while hunting costs one frame at most: the first
              // byte check that finds neither code drops back to hunting.
              next_r.align = lfp_hunt;
            end
          end
        end
        lfp_inframe: begin
          if (byte_done(r.bit_cnt)) begin
            mod_word = word;
            if (!odd_ok(word)) begin
              perr_set = 1'b1;
              next_r.perr = 1'b1;
            end
            unique case (r.byte_cnt)
              lfp_byte_addr: begin
                if (wbyte == lfp_code_all) begin
                  next_r.fr_bcast = 1'b1;
                end else if (wbyte == r.own_addr && r.enable) begin
                  next_r.fr_own = 1'b1;
                  mod_word = odd_word(r.own_addr);
                end else if (wbyte == lfp_code_any && r.enable && r.svc_req
                             && r.op == lfp_idle && r.own_addr[lfp_addr_top]) begin
                  next_r.fr_cap = 1'b1;
                  mod_word = odd_word(r.own_addr);
                end
              end
              lfp_byte_dev: begin
                if (r.fr_cap) begin
                  mod_word = odd_word(r.dev_addr);
                end
              end
              lfp_byte_ctl: begin
                cmd = wbyte;
                // Only a byte with a zero response nibble is a command.
                next_r.fr_cmd = is_cmd(cmd);
                diag_cmd = (cmd == lfp_cmd_diag_begin) || (cmd == lfp_cmd_diag_end);
                if (next_r.fr_cmd && r.fr_cap) begin
                  if (cmd == lfp_cmd_read_null) begin
                    mod_word = odd_word(lfp_rsp_read_req);
                    next_r.op = lfp_claimed;
                    // One request claims one frame; software asks again for the next.
                    next_r.svc_req = 1'b0;
                  end
                end else if (next_r.fr_cmd && (r.fr_own || r.fr_bcast) && diag_cmd) begin
                  // Device byte is ignored for diagnostics.
                  next_r.diag = (cmd == lfp_cmd_diag_begin);
                  if (r.fr_own) begin
                    mod_word = odd_word((cmd == lfp_cmd_diag_begin) ?
                                        lfp_rsp_diag_begin : lfp_rsp_diag_end);
                  end
                end else if (next_r.fr_cmd && r.fr_own) begin
                  unique case (r.op)
                    lfp_claimed: begin
                      if (cmd == lfp_cmd_read) begin
                        mod_word = odd_word(lfp_rsp_read_ack);
                        next_r.op = lfp_datamode;
                      end
                    end
                    lfp_datamode: begin
                      if (cmd == lfp_cmd_read_null) begin
                        if (r.tx_avail) begin
                          mod_word = odd_word(lfp_rsp_data_req);
                          next_r.fr_data_sel = sel_tx;
                        end else if (r.end_req) begin
                          mod_word = odd_word(lfp_rsp_end_req);
                          next_r.fr_data_sel = sel_end;
                        end else begin
                          mod_word = odd_word(lfp_rsp_null_ack);
                        end
                      end else if (cmd == lfp_cmd_read_data && r.tx_avail) begin
                        // Second copy of the byte; then it is released.
                        mod_word = odd_word(lfp_rsp_data_ack);
                        next_r.fr_data_sel = sel_tx;
                        next_r.tx_avail = 1'b0;
                      end else if (cmd == lfp_cmd_read_end) begin
                        mod_word = odd_word(lfp_rsp_end_ack);
                        next_r.op = lfp_idle;
                        next_r.end_req = 1'b0;
                        next_r.fr_data_sel = sel_guide;
                      end
                    end
                    default: begin
                    end
                  endcase
                end
              end
              lfp_byte_data: begin
                // Data is forwarded as received unless this station fills it.
                unique case (r.fr_data_sel)
                  sel_tx: mod_word = odd_word(r.tx_byte);
                  sel_end: mod_word = odd_word(r.end_status);
                  default: mod_word = word;
                endcase
                // Only the data byte of a read end frame is taken as guidance.
                if (r.fr_data_sel == sel_guide) begin
                  next_r.guidance = wbyte;
                end
              end
              default: begin
              end
            endcase
            next_r.delay = mod_word;
            if (r.byte_cnt == lfp_last_byte) begin
              next_r.align = lfp_between;
            end else begin
              next_r.byte_cnt = r.byte_cnt + 3'h1;
            end
          end
        end
        default: begin
          next_r.align = lfp_hunt;
        end
      endcase
    end

    // Command port: writes.
    if (reg_wr) begin
      unique case (reg_addr)
        lfp_reg_ctrl: next_r.enable = reg_wdata[lfp_ctrl_enable];
        lfp_reg_addr: begin
          next_r.own_addr = reg_wdata[7:0];
          next_r.dev_addr = reg_wdata[15:8];
        end
        lfp_reg_txdata: begin
          // A byte still unsent is kept; software must poll first.
          if (!r.tx_avail) begin
            next_r.tx_byte = reg_wdata[7:0];
            next_r.tx_avail = 1'b1;
          end
        end
        lfp_reg_end: begin
          // A second write before the frame goes out replaces the status.
          next_r.end_status = reg_wdata[7:0];
          next_r.end_req = 1'b1;
        end
        lfp_reg_req: next_r.svc_req = 1'b1;
        lfp_reg_status: begin
          // A parity fault seen in this same cycle is kept.
          if (reg_wdata[lfp_status_perr] && !perr_set) begin
            next_r.perr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Command port: read data stand one cycle after the strobe.
    // Zero outside that cycle, so several ports may share one OR-ed bus.
    next_r.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        lfp_reg_ctrl: next_r.rdata = {15'h0000, r.enable};
        lfp_reg_addr: next_r.rdata = {r.dev_addr, r.own_addr};
        lfp_reg_txdata: next_r.rdata = {7'h00, r.tx_avail, r.tx_byte};
        lfp_reg_end: next_r.rdata = {7'h00, r.end_req, r.end_status};
        lfp_reg_req: next_r.rdata = {15'h0000, r.svc_req};
        lfp_reg_status: next_r.rdata = {r.guidance, r.diag, r.op, r.align, 2'b00, r.perr};
        default: next_r.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset is taken at once; the loop outputs drop to zero and hunting starts again.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= lfp_reset;
    end else begin
      r <= next_r;
    end
  end

  assign loop_clk_out = r.out_clk;
  assign loop_data_out = r.out_bit;
  assign reg_rdata = r.rdata;

endmodule // lfp_station

// [lfp_station_checker.sv]
// Port checker for the loop station: command port and loop timing.
// Bound to lfp_station; sees only its ports.
`timescale 1ns/1ns
module lfp_station_checker
  import lfp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic loop_clk_in,
  input wire logic loop_data_in,
  input wire logic loop_clk_out,
  input wire logic loop_data_out,
  input wire logic [lfp_pkg::lfp_reg_aw-1:0] reg_addr,
  input wire logic [lfp_pkg::lfp_reg_dw-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lfp_pkg::lfp_reg_dw-1:0] reg_rdata
);
  logic [15:0] wd1;
  logic [15:0] wd2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Write data of two cycles back, for a write followed at once by a read.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd1 <= 16'h0000;
      wd2 <= 16'h0000;
    end else begin
      wd1 <= reg_wdata;
      wd2 <= wd1;
    end
  end
  sequence s_wr_rd(a);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
  endsequence
  ////////////////////////////////////////
  AST_QUIET_START:
    assert property ($rose(rstn) |-> !loop_clk_out && !loop_data_out)
    else $error("loop outputs busy at reset release");
  AST_RDATA_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data without a read strobe");
  AST_UNMAPPED:
    assert property ($past(reg_rd) && $past(reg_addr) > lfp_reg_status |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_STATUS_GAP:
    assert property ($past(reg_rd) && $past(reg_addr) == lfp_reg_status |-> reg_rdata[2:1] == 2'h0)
    else $error("status unused bits set");
  AST_CTRL_BACK:
    assert property (s_wr_rd(lfp_reg_ctrl) |=> reg_rdata[lfp_ctrl_enable] == wd2[lfp_ctrl_enable])
    else $error("enable readback wrong");
  AST_ADDR_BACK:
    assert property (s_wr_rd(lfp_reg_addr) |=> reg_rdata == wd2)
    else $error("address readback wrong");
  AST_CLK_FOLLOW:
    assert property ($rose(loop_clk_in) |-> ##[2:6] $rose(loop_clk_out))
    else $error("loop clock not forwarded");
  AST_CLK_HELD:
    assert property ($rose(loop_clk_out) |=> loop_clk_out [*3])
    else $error("forwarded loop clock glitch");
  AST_DOUT_STEADY:
    assert property ($fell(loop_clk_out) |=> $stable(loop_data_out) [*4])
    else $error("loop data moved between bit events");
endmodule // lfp_station_checker
bind lfp_station lfp_station_checker i_chk (.clk(clk), .rstn(rstn), .loop_clk_in(loop_clk_in),
  .loop_data_in(loop_data_in), .loop_clk_out(loop_clk_out), .loop_data_out(loop_data_out),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

// [lfp_adapter.sv]
// Loop adapter model: free-running loop clock, frames and sync fill.
// The bench sets the f_ fields and pend, then waits for served to step.
`timescale 1ns/1ns
module lfp_adapter
  import lfp_pkg::*;
#(
  parameter int unsigned half_clks = 8
)
(
  input wire logic clk,
  output logic loop_clk,
  output logic loop_data,
  input wire logic ret_data
);
  // A short bit keeps the run small; the station only needs 4 clocks a phase.
  logic [44:0] obuf;
  logic [7:0] f_addr, f_dev, f_data;
  logic [3:0] f_cmd;
  logic [7:0] rx [0:4];
  logic pend, bad, mine, rx_perr;
  int unsigned served;
  task automatic send_bit(input logic b);
    @(posedge clk);
    loop_clk <= 1'b0;
    loop_data <= b;
    repeat (half_clks) @(posedge clk);
    loop_clk <= 1'b1;
    repeat (half_clks) @(posedge clk);
    obuf = {obuf[43:0], ret_data};
  endtask
  task automatic send_byte(input logic [7:0] b, input logic even, input logic flip);
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i]);
    end
    send_bit((even ? ^b : ~^b) ^ flip);
  endtask
  ////////////////////////////////////////
  initial begin
    loop_clk = 1'b0;
    loop_data = 1'b0;
    obuf = '0;
    pend = 1'b0;
    bad = 1'b0;
    served = 0;
    forever begin
      mine = pend;
      send_byte(lfp_code_start, 1'b1, 1'b0);
      send_byte(mine ? f_addr : 8'h90, 1'b0, 1'b0);
      send_byte(mine ? f_dev : 8'h40, 1'b0, 1'b0);
      send_byte({4'h0, mine ? f_cmd : 4'h2}, 1'b0, 1'b0);
      send_byte(mine ? f_data : 8'h00, 1'b0, mine & bad);
      send_byte(lfp_code_sync, 1'b0, 1'b0);
      rx_perr = 1'b0;
      for (int k = 0; k < 5; k++) begin
        rx[k] = obuf[44-9*k -: 8];
        rx_perr |= obuf[36-9*k] != ((k == 0) ? ^rx[k] : ~^rx[k]);
      end
      if (mine) begin
        pend = 1'b0;
        served++;
      end
      repeat (24) send_byte(lfp_code_sync, 1'b0, 1'b0);
    end
  end
endmodule // lfp_adapter

// [lfp_station_tb.sv]
// Self-checking bench: command port tasks and adapter frames.
// Needs lfp_adapter and the bound checker compiled first.
`timescale 1ns/1ns
module lfp_station_tb;
  import lfp_pkg::*;
  localparam logic [7:0] own = 8'h85;
  localparam logic [7:0] dv = 8'h40;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic lclk, ldat, lclk_out, dout;
  logic [15:0] reg_rdata, v;
  int err_count = 0;
  int checks_done = 0;
  lfp_adapter i_adp (.clk(clk), .loop_clk(lclk), .loop_data(ldat), .ret_data(dout));
  lfp_station i_dut (.clk(clk), .rstn(rstn), .loop_clk_in(lclk), .loop_data_in(ldat),
    .loop_clk_out(lclk_out), .loop_data_out(dout), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    check(n, {8'h00, e}, {8'h00, g});
  endtask
  // A write straight after a write waits an edge so reg_wr is never set twice at once.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    if (reg_wr === 1'b1) @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string n);
    rd(a, v);
    check(n, e, v);
  endtask
  // An expected control byte of ff means the control byte is not compared.
  task automatic frame(input logic [7:0] a, d, input logic [3:0] c, input logic [7:0] x,
      input logic b, input logic [7:0] ec, ex);
    int unsigned s;
    int n;
    s = i_adp.served;
    i_adp.f_addr = a;
    i_adp.f_dev = d;
    i_adp.f_cmd = c;
    i_adp.f_data = x;
    i_adp.bad = b;
    i_adp.pend = 1'b1;
    n = 0;
    while (i_adp.served == s && n < 12000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 12000) begin
      err_count++;
      $display("[ERR] frame expected reply seen timeout");
      stop_test();
    end
    check_byte("ret start", lfp_code_start, i_adp.rx[0]);
    check_byte("ret addr", (a == lfp_code_any) ? own : a, i_adp.rx[1]);
    if (a == lfp_code_any) check_byte("ret dev", dv, i_adp.rx[2]);
    if (ec !== 8'hff) check_byte("ret ctl", ec, i_adp.rx[3]);
    check_byte("ret data", ex, i_adp.rx[4]);
    if (!b) check("ret parity", 16'h0000, {15'h0000, i_adp.rx_perr});
  endtask
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(lfp_reg_status, 16'h0000, "status");
    rd_chk(lfp_reg_ctrl, 16'h0000, "ctrl");
    rd_chk(lfp_reg_addr, {lfp_dev_reset, lfp_own_reset}, "addr");
    rd_chk(4'h9, 16'h0000, "unmapped");
    tend("reset");
    wr(lfp_reg_addr, {dv, own});
    rd_chk(lfp_reg_addr, {dv, own}, "addr");
    wr(lfp_reg_ctrl, 16'h0001);
    rd_chk(lfp_reg_ctrl, 16'h0001, "ctrl");
    wr(lfp_reg_req, 16'h0001);
    frame(8'h90, dv, 4'h2, 8'h00, 1'b0, 8'h02, 8'h00);
    frame(lfp_code_any, 8'h3f, 4'h2, 8'h00, 1'b0, lfp_rsp_read_req, 8'h00);
    rd_chk(lfp_reg_status, 16'h0028, "status claimed");
    tend("claim");
    frame(own, dv, 4'h6, 8'h00, 1'b0, lfp_rsp_read_ack, 8'h00);
    rd_chk(lfp_reg_status, 16'h0048, "status data mode");
    wr(lfp_reg_txdata, 16'h005a);
    rd_chk(lfp_reg_txdata, 16'h015a, "txdata");
    frame(own, dv, 4'h2, 8'h00, 1'b0, lfp_rsp_data_req, 8'h5a);
    frame(own, dv, 4'ha, 8'h00, 1'b0, lfp_rsp_data_ack, 8'h5a);
    rd(lfp_reg_txdata, v);
    check("tx pending", 16'h0000, v & 16'h0100);
    frame(own, dv, 4'h2, 8'h00, 1'b0, lfp_rsp_null_ack, 8'h00);
    wr(lfp_reg_end, 16'h0000);
    frame(own, dv, 4'h2, 8'h00, 1'b0, lfp_rsp_end_req, 8'h00);
    frame(own, dv, 4'he, 8'h80, 1'b0, lfp_rsp_end_ack, 8'h80);
    rd_chk(lfp_reg_status, 16'h8008, "status end");
    tend("read");
    frame(own, 8'h3f, 4'h8, 8'h00, 1'b0, lfp_rsp_diag_begin, 8'h00);
    rd_chk(lfp_reg_status, 16'h8088, "status diag");
    frame(lfp_code_all, 8'h3f, 4'hc, 8'h00, 1'b0, 8'hff, 8'h00);
    rd_chk(lfp_reg_status, 16'h8008, "status diag end");
    tend("diag");
    frame(own, dv, 4'h2, 8'h00, 1'b1, 8'hff, 8'h00);
    rd(lfp_reg_status, v);
    check("parity flag", 16'h0001, v & 16'h0001);
    wr(lfp_reg_status, 16'h0001);
    rd(lfp_reg_status, v);
    check("parity clear", 16'h0000, v & 16'h0001);
    tend("parity");
    stop_test();
  end
endmodule // lfp_station_tb
